// [hdl/lcdt_edge_tap.sv]
`timescale 1ns/10ps
// Picks one stage of a divider chain and gives a one-cycle pulse on its rising edge.
module lcdt_edge_tap (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [lcdt_pkg::DIV_W-1:0] chain,
    input wire logic [4:0] stage,
    output logic pulse
);

    // State of the tap: the previous level of the chosen stage and which stage that was.
    typedef struct packed {
        logic last;
        logic [4:0] last_stage;
    } lcdt_tap_t;

    lcdt_tap_t st;
    lcdt_tap_t next_st;
    logic level;

    // The chosen stage toggles at the chain input rate over 2^(stage+1).
    // A change of stage would compare two different bits, so that cycle gives no pulse.
    always_comb begin
        level = chain[stage];
        next_st.last = level;
        next_st.last_stage = stage;
        pulse = level & ~st.last & (stage == st.last_stage);
    end

    // Registers the previous level.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// [hdl/lcdt_pkg.sv]
// Notes on behaviour
// R1: Four drive methods: quarter, third, half, static.
// R2: Frame base comes from clock in use.
// R3: Main clock base divides 2^17/16/15/13.
// R4: Frame is base, 4/3 base, or 2x base.
// R5: Sub clock base divides 2^9 or 2^8.
// R6: Booster select picks booster or resistor divider.
// R7: Boost clock select sets booster switching divider.
// R8: Software avoids half/static duty with booster.
// R9: Software avoids base codes 10/11 in slow.
// R10: Software avoids boost code 11 in slow.
// R11: Commons scan one per base period, restart.
package lcdt_pkg;

    // Drive-method field encodings.
    localparam logic [1:0] DUTY_QUARTER = 2'h0;
    localparam logic [1:0] DUTY_THIRD = 2'h1;
    localparam logic [1:0] DUTY_HALF = 2'h2;
    localparam logic [1:0] DUTY_STATIC = 2'h3;

    // Width of the free-running divider chains.
    localparam int DIV_W = 18;

    // Main-clock divider exponents for frame base select codes 0 to 3.
    localparam int MAIN_BASE_EXP0 = 17;
    localparam int MAIN_BASE_EXP1 = 16;
    localparam int MAIN_BASE_EXP2 = 15;
    localparam int MAIN_BASE_EXP3 = 13;
    // Sub-clock divider exponents for frame base select codes 0 and 1.
    localparam int SUB_BASE_EXP0 = 9;
    localparam int SUB_BASE_EXP1 = 8;
    // Main-clock boost exponents for boost clock select codes 0 to 3.
    localparam int MAIN_BOOST_EXP0 = 13;
    localparam int MAIN_BOOST_EXP1 = 11;
    localparam int MAIN_BOOST_EXP2 = 10;
    localparam int MAIN_BOOST_EXP3 = 9;
    // Sub-clock boost exponents for boost clock select codes 0 to 2.
    localparam int SUB_BOOST_EXP0 = 5;
    localparam int SUB_BOOST_EXP1 = 3;
    localparam int SUB_BOOST_EXP2 = 2;

    // Reset value of the control fields.
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Control register fields as software writes them.
    typedef struct packed {
        logic display_enable;
        logic booster_select;
        logic [1:0] boost_clock_select;
        logic [1:0] drive_method;
        logic [1:0] frame_base_select;
    } lcdt_ctrl_t;

    // Status shown toward the panel and the analog levels.
    typedef struct packed {
        logic [3:0] common_active;
        logic [1:0] common_index;
        logic base_tick;
        logic frame_start;
        logic boost_clk;
        logic booster_on;
        logic divider_on;
    } lcdt_drive_t;

endpackage

// [hdl/lcdt_timing.sv]
`timescale 1ns/10ps
// Frame timing, common scan and booster clock for the segment LCD driver.
// Main and sub clocks arrive as levels, synchronised on this clock; each rising edge advances its divider.
module lcdt_timing (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic main_clock,
    input wire logic sub_clock,
    input wire logic stage7_clock_select,
    input wire logic system_clock_select,
    input wire lcdt_pkg::lcdt_ctrl_t ctrl,
    output lcdt_pkg::lcdt_drive_t drive
);

    // All state of the block in one record, except what the main-clock tap keeps.
    typedef struct packed {
        logic [1:0] sync_main;
        logic [1:0] sync_sub;
        logic last_main;
        logic last_sub;
        logic [lcdt_pkg::DIV_W-1:0] main_div;
        logic [lcdt_pkg::DIV_W-1:0] sub_div;
        logic [1:0] com;
        logic [1:0] sub_base;
        logic boost_clk;
        logic base_tick;
        logic frame_start;
        logic [3:0] com_onehot;
    } lcdt_state_t;

    // Registered state and its next value.
    lcdt_state_t st;
    lcdt_state_t next_st;
    // Rising edges of the synchronised source clocks.
    logic main_edge;
    logic sub_edge;
    // High when the sub clock supplies the frame base.
    logic use_sub;
    // Divider stages picked for the frame base and for the booster.
    logic [4:0] base_stage;
    logic [4:0] boost_stage;
    // Base pulses from each chain and the one in use.
    logic main_base_pulse;
    logic sub_base_pulse;
    logic base_pulse;
    // Last common index of the selected drive method.
    logic [1:0] last_com;

    // Number of the last common scanned for a drive method.
    function automatic logic [1:0] last_common(input logic [1:0] method);
        case (method)
            lcdt_pkg::DUTY_QUARTER: last_common = 2'h3;
            lcdt_pkg::DUTY_THIRD: last_common = 2'h2;
            lcdt_pkg::DUTY_HALF: last_common = 2'h1;
            default: last_common = 2'h0;
        endcase
    endfunction

    // Divider stage index for a given power of two.
    function automatic logic [4:0] stage_of(input int exponent);
        stage_of = 5'(exponent - 1);
    endfunction

    // The sub clock supplies the base in dual mode with either select set.
    assign use_sub = stage7_clock_select | system_clock_select; // R2

    // Chooses the main-clock tap for the frame base.
    always_comb begin
        case (ctrl.frame_base_select) // R3
            2'h0: base_stage = stage_of(lcdt_pkg::MAIN_BASE_EXP0);
            2'h1: base_stage = stage_of(lcdt_pkg::MAIN_BASE_EXP1);
            2'h2: base_stage = stage_of(lcdt_pkg::MAIN_BASE_EXP2);
            default: base_stage = stage_of(lcdt_pkg::MAIN_BASE_EXP3);
        endcase
    end

    // Chooses the booster tap; code 11 has no sub-clock choice and uses main.
    always_comb begin
        if (use_sub && ctrl.boost_clock_select != 2'h3) begin
            case (ctrl.boost_clock_select) // R7
                2'h0: boost_stage = stage_of(lcdt_pkg::SUB_BOOST_EXP0);
                2'h1: boost_stage = stage_of(lcdt_pkg::SUB_BOOST_EXP1);
                default: boost_stage = stage_of(lcdt_pkg::SUB_BOOST_EXP2);
            endcase
        end else begin
            case (ctrl.boost_clock_select) // R7
                2'h0: boost_stage = stage_of(lcdt_pkg::MAIN_BOOST_EXP0);
                2'h1: boost_stage = stage_of(lcdt_pkg::MAIN_BOOST_EXP1);
                2'h2: boost_stage = stage_of(lcdt_pkg::MAIN_BOOST_EXP2);
                default: boost_stage = stage_of(lcdt_pkg::MAIN_BOOST_EXP3);
            endcase
        end
    end

    // Rising-edge pulse on the chosen main-clock stage.
    lcdt_edge_tap u_main_tap (
        .clock(clock),
        .rst_n(rst_n),
        .chain(st.main_div),
        .stage(base_stage),
        .pulse(main_base_pulse)
    );

    // Sub clock base: 2^8 or 2^9 stage, picked without a second tap module.
    assign sub_base_pulse = (ctrl.frame_base_select[0] ? // R5
        (st.sub_div[lcdt_pkg::SUB_BASE_EXP1-1] & ~st.sub_base[0]) :
        (st.sub_div[lcdt_pkg::SUB_BASE_EXP0-1] & ~st.sub_base[1]));

    assign base_pulse = use_sub ? sub_base_pulse : main_base_pulse; // R2
    assign main_edge = st.sync_main[1] & ~st.last_main;
    assign sub_edge = st.sync_sub[1] & ~st.last_sub;
    assign last_com = last_common(ctrl.drive_method); // R1

    // Next-state logic: dividers, boost clock and the common scan.
    always_comb begin
        next_st = st;
        next_st.sync_main = {st.sync_main[0], main_clock};
        next_st.sync_sub = {st.sync_sub[0], sub_clock};
        next_st.last_main = st.sync_main[1];
        next_st.last_sub = st.sync_sub[1];
        // Counters advance on each rising edge of their source clock.
        if (main_edge) begin
            next_st.main_div = st.main_div + 1'b1;
        end
        if (sub_edge) begin
            next_st.sub_div = st.sub_div + 1'b1;
        end
        next_st.sub_base = {st.sub_div[lcdt_pkg::SUB_BASE_EXP0-1], st.sub_div[lcdt_pkg::SUB_BASE_EXP1-1]};
        // Booster switching clock is the chosen divider stage.
        if (use_sub && ctrl.boost_clock_select != 2'h3) begin
            next_st.boost_clk = st.sub_div[boost_stage]; // R7
        end else begin
            next_st.boost_clk = st.main_div[boost_stage]; // R7
        end
        next_st.base_tick = base_pulse;
        next_st.frame_start = 1'b0;
        // One common per base period; wrap gives 4/3 and 2x frame rates.
        if (base_pulse) begin
            if (st.com >= last_com) begin // R11 R4
                next_st.com = 2'h0;
                next_st.frame_start = 1'b1;
            end else begin
                next_st.com = st.com + 1'b1; // R11
            end
        end
        next_st.com_onehot = 4'h1 << next_st.com;
    end

    // Registers the whole state.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs; the commons are only driven while the display is enabled, the booster and divider selects are not gated.
    // The booster clock is gated so that it stays low while the resistor divider is in use.
    always_comb begin
        drive.common_active = ctrl.display_enable ? st.com_onehot : 4'h0;
        drive.common_index = st.com;
        drive.base_tick = st.base_tick;
        drive.frame_start = st.frame_start;
        drive.boost_clk = ctrl.booster_select & st.boost_clk; // R6
        drive.booster_on = ctrl.booster_select; // R6
        drive.divider_on = ~ctrl.booster_select; // R6
    end

    // Common index does not exceed the last common of the method on a base tick while the method is unchanged.
    a_com_range: assert property (@(posedge clock) disable iff (!rst_n) // R11
        $stable(ctrl.drive_method) && st.base_tick |-> st.com <= last_com)
        else $error("common out of range");

    // A frame start puts the scan back on the first common.
    a_frame_first: assert property (@(posedge clock) disable iff (!rst_n) // R11
        st.frame_start |-> st.com == 2'h0)
        else $error("frame not at first common");

    // Static method starts a frame on every base tick.
    a_static_frame: assert property (@(posedge clock) disable iff (!rst_n) // R4
        ctrl.drive_method == lcdt_pkg::DUTY_STATIC && $past(ctrl.drive_method) == lcdt_pkg::DUTY_STATIC
        && st.base_tick |-> st.frame_start)
        else $error("static frame missed");

    // Booster clock is silent with the resistor divider.
    a_boost_off: assert property (@(posedge clock) disable iff (!rst_n) // R6
        !ctrl.booster_select |-> !drive.boost_clk && drive.divider_on)
        else $error("booster active");

    // Scan advances by one on a base tick that does not wrap.
    a_scan_step: assert property (@(posedge clock) disable iff (!rst_n) // R11
        base_pulse && st.com < last_com |=> st.com == $past(st.com) + 2'h1)
        else $error("scan step");

    // In sub mode a base pulse marks the chosen sub stage rising with all lower bits clear.
    a_base_src: assert property (@(posedge clock) disable iff (!rst_n) // R2
        use_sub && base_pulse |-> (ctrl.frame_base_select[0] ?
        st.sub_div[lcdt_pkg::SUB_BASE_EXP1-1:0] == 8'h80 : st.sub_div[lcdt_pkg::SUB_BASE_EXP0-1:0] == 9'h100))
        else $error("wrong base source");

    // In main mode a base pulse marks the chosen main stage rising with all lower bits clear.
    a_main_src: assert property (@(posedge clock) disable iff (!rst_n) // R3
        !use_sub && base_pulse |-> st.main_div[base_stage]
        && ((st.main_div << (lcdt_pkg::DIV_W - int'(base_stage))) == '0))
        else $error("main base mismatch");

    // A sub base pulse lasts a single cycle.
    a_sub_edge: assert property (@(posedge clock) disable iff (!rst_n) // R5
        sub_base_pulse |=> !sub_base_pulse)
        else $error("sub base glitch");

    // A frame only starts once the scan has passed the last common, which sets the frame rate.
    a_wrap_last: assert property (@(posedge clock) disable iff (!rst_n) // R4
        st.frame_start |-> $past(st.com) >= $past(last_com))
        else $error("frame started early");

    // With the display on, exactly the indexed common is active.
    a_common_onehot: assert property (@(posedge clock) disable iff (!rst_n) // R11
        ctrl.display_enable && $past(rst_n) |-> drive.common_active == (4'h1 << st.com))
        else $error("common not one-hot");

endmodule

// [tb/lcd_drive_timing_select_tb.sv]
`timescale 1ns/10ps
// Bench for the LCD frame and booster timing; each running source clock toggles every two clocks.
module lcd_drive_timing_select_tb;
    logic clock, rst_n, main_clock, sub_clock, stage7_clock_select, system_clock_select;
    logic main_run, sub_run, ph, b_q;
    lcdt_pkg::lcdt_ctrl_t ctrl;
    lcdt_pkg::lcdt_drive_t drive;
    logic [3:0] frame_len;
    logic [7:0] panel_errs;
    int mismatches, n_tests, cycles;
    // System clock, 8 ns.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    lcdt_timing i_dut (.clock(clock), .rst_n(rst_n), .main_clock(main_clock), .sub_clock(sub_clock),
        .stage7_clock_select(stage7_clock_select), .system_clock_select(system_clock_select),
        .ctrl(ctrl), .drive(drive));
    lcdt_panel_model i_panel (.clock(clock), .drive(drive), .frame_len(frame_len), .panel_errs(panel_errs));
    // Source pins; a stopped source shows whether the design picked the right one.
    always @(negedge clock) begin
        ph <= ~ph;
        if (ph) begin
            if (main_run) main_clock <= ~main_clock;
            if (sub_run) sub_clock <= ~sub_clock;
        end
    end
    // Delayed booster clock for edge detection, and the hang limit.
    always @(posedge clock) begin
        b_q <= drive.boost_clk;
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            give_verdict();
        end
    end
    // Compares one result and counts it.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task give_verdict();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Applies a whole configuration off the sampling edge.
    task set_mode(input logic s7, sy, input logic [1:0] fb, input logic bs, input logic [1:0] bc, dm,
                  input logic mr, sr);
        @(negedge clock);
        stage7_clock_select = s7;
        system_clock_select = sy;
        ctrl = {1'b1, bs, bc, dm, fb};
        main_run = mr;
        sub_run = sr;
    endtask
    // Counts cycles up to the next base tick or rising booster edge.
    task automatic wait_ev(input logic boost, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (n < 40000 && !(boost ? (drive.boost_clk === 1'b1 && b_q === 1'b0) : drive.base_tick === 1'b1));
    endtask
    // Lets one event pass to settle, then times one full period.
    task automatic measure(input logic boost, input int exp);
        int n;
        wait_ev(boost, n);
        wait_ev(boost, n);
        chk(n, exp);
    endtask
    // Each drive method must scan its own number of commons per frame; booster kept off.
    task automatic t_duty();
        for (int d = 0; d < 4; d++) begin
            set_mode(1'b1, 1'b0, 2'h1, 1'b0, 2'h0, 2'(d), 1'b0, 1'b1);
            repeat (2) begin
                do @(posedge clock); while (drive.frame_start !== 1'b1);
            end
            @(posedge clock);
            chk(frame_len, 4 - d);
        end
    endtask
    // Sub-clock base periods through both select pins.
    task t_base();
        set_mode(1'b0, 1'b1, 2'h0, 1'b0, 2'h0, lcdt_pkg::DUTY_QUARTER, 1'b0, 1'b1);
        measure(1'b0, 2048);
        set_mode(1'b1, 1'b0, 2'h1, 1'b0, 2'h0, lcdt_pkg::DUTY_QUARTER, 1'b0, 1'b1);
        measure(1'b0, 1024);
    endtask
    // Booster clock for every code, then the resistor divider with the booster quiet.
    task automatic t_boost();
        logic hi;
        for (int c = 0; c < 3; c++) begin
            set_mode(1'b1, 1'b0, 2'h1, 1'b1, 2'(c), lcdt_pkg::DUTY_THIRD, 1'b0, 1'b1);
            @(posedge clock);
            chk({drive.booster_on, drive.divider_on}, 2'h2);
            measure(1'b1, c == 0 ? 128 : (c == 1 ? 32 : 16));
        end
        set_mode(1'b1, 1'b0, 2'h1, 1'b1, 2'h3, lcdt_pkg::DUTY_THIRD, 1'b1, 1'b0);
        measure(1'b1, 2048);
        set_mode(1'b1, 1'b0, 2'h1, 1'b0, 2'h2, lcdt_pkg::DUTY_QUARTER, 1'b1, 1'b1);
        hi = 1'b0;
        repeat (64) begin
            @(posedge clock);
            hi = hi | drive.boost_clk;
        end
        chk({drive.booster_on, drive.divider_on, hi}, 3'h2);
    endtask
    // Main-clock base at the fastest code.
    task t_main();
        set_mode(1'b0, 1'b0, 2'h3, 1'b0, 2'h0, lcdt_pkg::DUTY_QUARTER, 1'b1, 1'b0);
        measure(1'b0, 32768);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        rst_n = 1'b0;
        {main_clock, sub_clock, stage7_clock_select, system_clock_select, main_run, sub_run, ph} = 7'h00;
        ctrl = lcdt_pkg::CTRL_RESET;
        repeat (12) @(negedge clock);
        chk({drive.common_index, drive.base_tick, drive.frame_start}, 4'h0);
        rst_n = 1'b1;
        t_duty();
        t_base();
        t_boost();
        t_main();
        chk(panel_errs, 8'h00);
        give_verdict();
    end
endmodule

// [tb/lcdt_panel_model.sv]
`timescale 1ns/10ps
// Panel model: watches the commons and records how many base periods the last frame lasted.
module lcdt_panel_model (
    input wire logic clock,
    input wire lcdt_pkg::lcdt_drive_t drive,
    output logic [3:0] frame_len,
    output logic [7:0] panel_errs
);
    // Base ticks seen since the last frame start, that tick included.
    logic [3:0] cnt;
    initial begin
        cnt = 4'h0;
        frame_len = 4'h0;
        panel_errs = 8'h00;
    end
    // On every base tick exactly the indexed common must be driven, and a frame starts at common 0.
    always @(posedge clock) begin
        if (drive.base_tick === 1'b1) begin
            if (drive.common_active !== (4'h1 << drive.common_index)) begin
                panel_errs <= panel_errs + 8'h01;
            end
            if (drive.frame_start === 1'b1) begin
                frame_len <= cnt;
                cnt <= 4'h1;
                if (drive.common_index !== 2'h0) begin
                    panel_errs <= panel_errs + 8'h01;
                end
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
